// ==== logic/kbc_pkg.sv ====
// ****************************************************************
// keyboard controller configuration constants
// ****************************************************************
package kbc_pkg;

  // ****************************************************************
  // register bus
  // ****************************************************************
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 8;
  localparam logic [7:0]  CFG_IDX    = 8'hF0;
  localparam logic [7:0]  RSV_LO_IDX = 8'hF1;
  localparam logic [7:0]  RSV_HI_IDX = 8'hFF;
  localparam logic [7:0]  STAT_IDX   = 8'hE0;
  localparam logic [7:0]  MASK_IDX   = 8'hE1;

  // ****************************************************************
  // configuration register layout
  // ****************************************************************
  localparam int          CFG_AUX_POL_BIT   = 7;
  localparam int          CFG_MOUSE_ISO_BIT = 6;
  localparam int          CFG_KBD_ISO_BIT   = 5;
  localparam int          CFG_MOUSE_IRQ_LATCH_SELECT_BIT    = 4;
  localparam int          CFG_KEYBOARD_IRQ_LATCH_SELECT_BIT    = 3;
  localparam int          CFG_GATE_EN_BIT   = 2;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  localparam logic [7:0]  CFG_WMASK         = 8'hFC;

  // ****************************************************************
  // event status and mask layout
  // ****************************************************************
  localparam int          EVT_W          = 3;
  localparam int          EVT_KBD_BIT    = 0;
  localparam int          EVT_MOUSE_BIT  = 1;
  localparam int          EVT_GATE_BIT   = 2;
  localparam logic [2:0]  STAT_RESET     = 3'h0;
  localparam logic [2:0]  MASK_RESET     = 3'h0;

  // ****************************************************************
  // fast gate port layout
  // ****************************************************************
  localparam int          GP_RESET_BIT   = 0;
  localparam int          GP_GATE_BIT    = 1;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          SYNC_STAGES    = 2;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          KRST_PULSE_NS  = 500;
  localparam int          KRST_PULSE_CYC =
    (KRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // pin synchroniser lanes
  // ****************************************************************
  localparam int          PIN_W          = 4;
  localparam int          PIN_KCLK       = 0;
  localparam int          PIN_KEYBOARD_DATA_LINE       = 1;
  localparam int          PIN_MCLK       = 2;
  localparam int          PIN_MOUSE_DATA_LINE       = 3;

endpackage

// ==== logic/kbc_irq_latch.sv ====
`timescale 1ns/1ps
// ****************************************************************
// interrupt latch for one controller interrupt
// ****************************************************************
module kbc_irq_latch (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_raw,
  input  wire logic i_ack,
  input  wire logic i_latch_select,
  output logic      o_irq,
  output logic      o_latched,
  output logic      o_set
);

  logic raw_q;
  logic rise;
  logic next_latched;

  // rising edge of the raw controller interrupt
  assign rise = i_raw & ~raw_q;

  // an edge in the ack cycle still latches: set beats clear
  always_comb begin
    next_latched = o_latched;
    if (rise) begin
      next_latched = 1'b1;
    end else if (i_ack) begin
      next_latched = 1'b0;
    end
  end

  // raw history and latch state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      raw_q     <= 1'b0;
      o_latched <= 1'b0;
      o_set     <= 1'b0;
    end else begin
      raw_q     <= i_raw;
      o_latched <= next_latched;
      o_set     <= rise;
    end
  end

  // selected form: latched copy alone, or anded with the raw level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else if (i_latch_select) begin
      o_irq <= next_latched;
    end else begin
      o_irq <= i_raw & next_latched;
    end
  end

  chk_latch_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rise |=> o_latched && o_set)
    else $error("latch missed a raw edge");

  chk_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_latched && !i_ack |=> o_latched)
    else $error("latch dropped without ack");

endmodule

// ==== logic/kbc_top.sv ====
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module kbc_top #(
  parameter int SYNC_STAGES    = kbc_pkg::SYNC_STAGES,
  parameter int KRST_PULSE_CYC = kbc_pkg::KRST_PULSE_CYC
) (
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RST_N,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  output logic            O_IRQ,
  input  wire logic       I_KBD_CLK,
  input  wire logic       I_KBD_DATA,
  input  wire logic       I_MOUSE_CLK,
  input  wire logic       I_MOUSE_DATA,
  output logic            O_KBD_CLK_TO_CTRL,
  output logic            O_KBD_DATA_TO_CTRL,
  output logic            O_MOUSE_CLK_TO_CTRL,
  output logic            O_MOUSE_DATA_TO_CTRL,
  output logic            O_KEYBOARD_DATA_LINE_WAKE,
  output logic            O_MOUSE_DATA_LINE_WAKE,
  input  wire logic       I_CTRL_AUX,
  output logic            O_AUX_CONTROLLER_OUTPUT,
  input  wire logic       I_CTRL_KBD_IRQ,
  input  wire logic       I_CTRL_MOUSE_IRQ,
  input  wire logic       I_KBD_IRQ_ACK,
  input  wire logic       I_MOUSE_IRQ_ACK,
  output logic            O_KEYBOARD_IRQ,
  output logic            O_MOUSE_IRQ,
  input  wire logic       I_GATE_PORT_WR,
  input  wire logic       I_GATE_PORT_RD,
  input  wire logic [7:0] I_GATE_PORT_WDATA,
  output logic      [7:0] O_GATE_PORT_RDATA,
  output logic            O_GATE_PORT_RESP,
  output logic            O_ADDRESS20_GATE,
  output logic            O_KEYBOARD_RESET_OUT
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  localparam int CNT_W = $clog2(KRST_PULSE_CYC + 1);

  generate
    if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
    end
    if (KRST_PULSE_CYC < 1) begin : g_bad_pulse
      $error("KRST_PULSE_CYC must be at least 1");
    end
  endgenerate

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]                 cfg;
  logic [kbc_pkg::EVT_W-1:0]  stat;
  logic [kbc_pkg::EVT_W-1:0]  mask;
  logic [kbc_pkg::EVT_W-1:0]  evt;
  logic [kbc_pkg::PIN_W-1:0]  pins;
  logic [kbc_pkg::PIN_W-1:0]  pin_sync;
  logic [7:0]                 next_rdata;
  logic                       cfg_wr;
  logic                       stat_wr;
  logic                       mask_wr;
  logic                       gate_en;
  logic                       gate_wr_ok;
  logic                       kbd_set;
  logic                       mouse_set;
  logic                       kbd_latched;
  logic                       mouse_latched;
  logic                       krst_load;
  logic [CNT_W-1:0]           krst_cnt;

  // ****************************************************************
  // register decode
  // ****************************************************************
  assign cfg_wr  = I_WR && (I_ADDR == kbc_pkg::CFG_IDX);
  assign stat_wr = I_WR && (I_ADDR == kbc_pkg::STAT_IDX);
  assign mask_wr = I_WR && (I_ADDR == kbc_pkg::MASK_IDX);
  assign gate_en = cfg[kbc_pkg::CFG_GATE_EN_BIT];

  // configuration register; low two bits never store
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      cfg <= kbc_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg <= I_WDATA & kbc_pkg::CFG_WMASK;
    end
  end

  // interrupt mask
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      mask <= kbc_pkg::MASK_RESET;
    end else if (mask_wr) begin
      mask <= I_WDATA[kbc_pkg::EVT_W-1:0];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped and reserved indexes answer zero
  always_comb begin
    next_rdata = 8'h00;
    if (I_ADDR == kbc_pkg::CFG_IDX) begin
      next_rdata = cfg & kbc_pkg::CFG_WMASK;
    end else if (I_ADDR == kbc_pkg::STAT_IDX) begin
      next_rdata = {5'h00, stat};
    end else if (I_ADDR == kbc_pkg::MASK_IDX) begin
      next_rdata = {5'h00, mask};
    end else if (I_ADDR >= kbc_pkg::RSV_LO_IDX) begin
      next_rdata = 8'h00;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= next_rdata;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  assign pins[kbc_pkg::PIN_KCLK] = I_KBD_CLK;
  assign pins[kbc_pkg::PIN_KEYBOARD_DATA_LINE] = I_KBD_DATA;
  assign pins[kbc_pkg::PIN_MCLK] = I_MOUSE_CLK;
  assign pins[kbc_pkg::PIN_MOUSE_DATA_LINE] = I_MOUSE_DATA;

  // pins are asynchronous; nothing reads the first stage but the next
  genvar gi;
  generate
    for (gi = 0; gi < kbc_pkg::PIN_W; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] chain;
      always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
          chain <= {SYNC_STAGES{1'b1}};
        end else begin
          chain <= {chain[SYNC_STAGES-2:0], pins[gi]};
        end
      end
      assign pin_sync[gi] = chain[SYNC_STAGES-1];
    end
  endgenerate

  // ****************************************************************
  // isolation toward the embedded controller
  // ****************************************************************
  // blocked lines idle high, the released level of an open-drain wire
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_KBD_CLK_TO_CTRL    <= 1'b1;
      O_KBD_DATA_TO_CTRL   <= 1'b1;
      O_MOUSE_CLK_TO_CTRL  <= 1'b1;
      O_MOUSE_DATA_TO_CTRL <= 1'b1;
    end else begin
      O_KBD_CLK_TO_CTRL    <= cfg[kbc_pkg::CFG_KBD_ISO_BIT] |
                              pin_sync[kbc_pkg::PIN_KCLK];
      O_KBD_DATA_TO_CTRL   <= cfg[kbc_pkg::CFG_KBD_ISO_BIT] |
                              pin_sync[kbc_pkg::PIN_KEYBOARD_DATA_LINE];
      O_MOUSE_CLK_TO_CTRL  <= cfg[kbc_pkg::CFG_MOUSE_ISO_BIT] |
                              pin_sync[kbc_pkg::PIN_MCLK];
      O_MOUSE_DATA_TO_CTRL <= cfg[kbc_pkg::CFG_MOUSE_ISO_BIT] |
                              pin_sync[kbc_pkg::PIN_MOUSE_DATA_LINE];
    end
  end

  // wake logic sees the data lines whatever the isolation says
  assign O_KEYBOARD_DATA_LINE_WAKE = pin_sync[kbc_pkg::PIN_KEYBOARD_DATA_LINE];
  assign O_MOUSE_DATA_LINE_WAKE    = pin_sync[kbc_pkg::PIN_MOUSE_DATA_LINE];

  // ****************************************************************
  // auxiliary output polarity
  // ****************************************************************
  // controller drives its port bit as plain asserted-high level
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_AUX_CONTROLLER_OUTPUT <= 1'b1;
    end else if (cfg[kbc_pkg::CFG_AUX_POL_BIT]) begin
      O_AUX_CONTROLLER_OUTPUT <= I_CTRL_AUX;
    end else begin
      O_AUX_CONTROLLER_OUTPUT <= ~I_CTRL_AUX;
    end
  end

  // ****************************************************************
  // keyboard and mouse interrupt shaping
  // ****************************************************************
  kbc_irq_latch u_kbd_latch (
    .i_clk          (I_SYS_CLK),
    .i_rst_n        (I_RST_N),
    .i_raw          (I_CTRL_KBD_IRQ),
    .i_ack          (I_KBD_IRQ_ACK),
    .i_latch_select (cfg[kbc_pkg::CFG_KEYBOARD_IRQ_LATCH_SELECT_BIT]),
    .o_irq          (O_KEYBOARD_IRQ),
    .o_latched      (kbd_latched),
    .o_set          (kbd_set)
  );

  kbc_irq_latch u_mouse_latch (
    .i_clk          (I_SYS_CLK),
    .i_rst_n        (I_RST_N),
    .i_raw          (I_CTRL_MOUSE_IRQ),
    .i_ack          (I_MOUSE_IRQ_ACK),
    .i_latch_select (cfg[kbc_pkg::CFG_MOUSE_IRQ_LATCH_SELECT_BIT]),
    .o_irq          (O_MOUSE_IRQ),
    .o_latched      (mouse_latched),
    .o_set          (mouse_set)
  );

  // ****************************************************************
  // fast gate port
  // ****************************************************************
  // a disabled port neither stores nor answers
  assign gate_wr_ok = I_GATE_PORT_WR && gate_en;
  assign krst_load  = gate_wr_ok &&
                      I_GATE_PORT_WDATA[kbc_pkg::GP_RESET_BIT] &&
                      (krst_cnt == '0);

  // gate level follows the written bit
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_ADDRESS20_GATE <= 1'b0;
    end else if (gate_wr_ok) begin
      O_ADDRESS20_GATE <= I_GATE_PORT_WDATA[kbc_pkg::GP_GATE_BIT];
    end
  end

  // reset pulse; a retrigger during the pulse is ignored
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      krst_cnt             <= '0;
      O_KEYBOARD_RESET_OUT <= 1'b0;
    end else if (krst_load) begin
      krst_cnt             <= CNT_W'(KRST_PULSE_CYC);
      O_KEYBOARD_RESET_OUT <= 1'b1;
    end else if (krst_cnt != '0) begin
      krst_cnt             <= krst_cnt - 1'b1;
      O_KEYBOARD_RESET_OUT <= (krst_cnt != CNT_W'(1));
    end
  end

  // port readback, one cycle after the read strobe
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_GATE_PORT_RESP  <= 1'b0;
      O_GATE_PORT_RDATA <= 8'h00;
    end else if (I_GATE_PORT_RD && gate_en) begin
      O_GATE_PORT_RESP  <= 1'b1;
      O_GATE_PORT_RDATA <= {6'h00, O_ADDRESS20_GATE, O_KEYBOARD_RESET_OUT};
    end else begin
      O_GATE_PORT_RESP  <= 1'b0;
      O_GATE_PORT_RDATA <= 8'h00;
    end
  end

  // ****************************************************************
  // event status and interrupt
  // ****************************************************************
  assign evt[kbc_pkg::EVT_KBD_BIT]   = kbd_set;
  assign evt[kbc_pkg::EVT_MOUSE_BIT] = mouse_set;
  assign evt[kbc_pkg::EVT_GATE_BIT]  = gate_wr_ok;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      stat <= kbc_pkg::STAT_RESET;
    end else if (stat_wr) begin
      stat <= (stat & ~I_WDATA[kbc_pkg::EVT_W-1:0]) | evt;
    end else begin
      stat <= stat | evt;
    end
  end

  // level output, no extra delay after status or mask changes
  assign O_IRQ = |(stat & mask);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  chk_aux_polarity: assert property (
    ##1 O_AUX_CONTROLLER_OUTPUT ==
      ($past(cfg[kbc_pkg::CFG_AUX_POL_BIT]) ?
       $past(I_CTRL_AUX) : !$past(I_CTRL_AUX)))
    else $error("aux output polarity wrong");

  chk_mouse_block: assert property (
    cfg[kbc_pkg::CFG_MOUSE_ISO_BIT] |=>
      O_MOUSE_CLK_TO_CTRL && O_MOUSE_DATA_TO_CTRL)
    else $error("mouse lines not blocked");

  chk_kbd_block: assert property (
    cfg[kbc_pkg::CFG_KBD_ISO_BIT] |=>
      O_KBD_CLK_TO_CTRL && O_KBD_DATA_TO_CTRL)
    else $error("keyboard lines not blocked");

  chk_wake_pass: assert property (
    ##2 O_MOUSE_DATA_LINE_WAKE == $past(I_MOUSE_DATA, 2) &&
      O_KEYBOARD_DATA_LINE_WAKE == $past(I_KBD_DATA, 2))
    else $error("wake data not passed");

  chk_mouse_irq: assert property (
    ##1 O_MOUSE_IRQ == ($past(cfg[kbc_pkg::CFG_MOUSE_IRQ_LATCH_SELECT_BIT]) ?
      mouse_latched : ($past(I_CTRL_MOUSE_IRQ) && mouse_latched)))
    else $error("mouse interrupt form wrong");

  chk_kbd_irq: assert property (
    ##1 O_KEYBOARD_IRQ == ($past(cfg[kbc_pkg::CFG_KEYBOARD_IRQ_LATCH_SELECT_BIT]) ?
      kbd_latched : ($past(I_CTRL_KBD_IRQ) && kbd_latched)))
    else $error("keyboard interrupt form wrong");

  chk_gate_refused: assert property (
    I_GATE_PORT_WR && !gate_en |=> $stable(O_ADDRESS20_GATE))
    else $error("disabled gate port stored");

  chk_gate_silent: assert property (
    I_GATE_PORT_RD && !gate_en |=> !O_GATE_PORT_RESP)
    else $error("disabled gate port answered");

  chk_rsvd_read: assert property (
    I_RD && I_ADDR >= kbc_pkg::RSV_LO_IDX |=> O_RDATA == 8'h00)
    else $error("reserved index read nonzero");

  chk_cfg_lowbits: assert property (
    I_RD && I_ADDR == kbc_pkg::CFG_IDX |=> O_RDATA[1:0] == 2'h0)
    else $error("reserved config bits read nonzero");

  chk_krst_width: assert property (
    $rose(O_KEYBOARD_RESET_OUT) |-> O_KEYBOARD_RESET_OUT [*8])
    else $error("reset pulse too short");

  // an unmasked status bit must stay up until software clears it
  chk_irq_level: assert property (
    (stat & mask) != '0 && !stat_wr && !mask_wr |=> O_IRQ)
    else $error("interrupt not raised");

  cov_mouse_iso: cover property (
    cfg_wr && I_WDATA[kbc_pkg::CFG_MOUSE_ISO_BIT] ##1 I_MOUSE_CLK);
  cov_gate_write: cover property (gate_wr_ok ##1 O_ADDRESS20_GATE);
  cov_irq_clear: cover property (O_IRQ ##1 stat_wr ##1 !O_IRQ);

endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic       i_sys_clk, i_rst_n, i_wr, i_rd;
  logic [7:0] i_addr, i_wdata, o_rdata, i_gp_wdata, o_gp_rdata;
  logic       o_irq, i_kclk, i_keyboard_data_line, i_mclk, i_mouse_data_line;
  logic       o_kclk_c, o_keyboard_data_line_c, o_mclk_c, o_mouse_data_line_c, o_kwake, o_mwake;
  logic       i_aux, o_aux, i_kraw, i_mraw, i_kack, i_mack;
  logic       o_kirq, o_mirq, i_gp_wr, i_gp_rd, o_gp_resp, o_a20, o_krst;
  int         failures;
  int         n_compared;

  kbc_top i_kbc_top (
    .I_SYS_CLK                 (i_sys_clk),
    .I_RST_N                   (i_rst_n),
    .I_ADDR                    (i_addr),
    .I_WDATA                   (i_wdata),
    .I_WR                      (i_wr),
    .I_RD                      (i_rd),
    .O_RDATA                   (o_rdata),
    .O_IRQ                     (o_irq),
    .I_KBD_CLK                 (i_kclk),
    .I_KBD_DATA                (i_keyboard_data_line),
    .I_MOUSE_CLK               (i_mclk),
    .I_MOUSE_DATA              (i_mouse_data_line),
    .O_KBD_CLK_TO_CTRL         (o_kclk_c),
    .O_KBD_DATA_TO_CTRL        (o_keyboard_data_line_c),
    .O_MOUSE_CLK_TO_CTRL       (o_mclk_c),
    .O_MOUSE_DATA_TO_CTRL      (o_mouse_data_line_c),
    .O_KEYBOARD_DATA_LINE_WAKE (o_kwake),
    .O_MOUSE_DATA_LINE_WAKE    (o_mwake),
    .I_CTRL_AUX                (i_aux),
    .O_AUX_CONTROLLER_OUTPUT   (o_aux),
    .I_CTRL_KBD_IRQ            (i_kraw),
    .I_CTRL_MOUSE_IRQ          (i_mraw),
    .I_KBD_IRQ_ACK             (i_kack),
    .I_MOUSE_IRQ_ACK           (i_mack),
    .O_KEYBOARD_IRQ            (o_kirq),
    .O_MOUSE_IRQ               (o_mirq),
    .I_GATE_PORT_WR            (i_gp_wr),
    .I_GATE_PORT_RD            (i_gp_rd),
    .I_GATE_PORT_WDATA         (i_gp_wdata),
    .O_GATE_PORT_RDATA         (o_gp_rdata),
    .O_GATE_PORT_RESP          (o_gp_resp),
    .O_ADDRESS20_GATE          (o_a20),
    .O_KEYBOARD_RESET_OUT      (o_krst)
  );

  // ****************************************************************
  // clock, 50 ns period
  // ****************************************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // four-state compare so an unknown never counts as a match
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    check(o_rdata, exp);
  endtask

  task automatic print_verdict;
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset values, reserved bits and the reserved index range
  task automatic t_regs;
    reg_rd(kbc_pkg::CFG_IDX, 8'h00);
    check({7'h00, o_aux}, 8'h01);
    reg_wr(kbc_pkg::CFG_IDX, 8'hFF);
    reg_rd(kbc_pkg::CFG_IDX, 8'hFC);
    reg_wr(kbc_pkg::CFG_IDX, 8'h03);
    reg_rd(kbc_pkg::CFG_IDX, 8'h00);
    for (int a = 8'hF1; a <= 8'hFF; a++) begin
      reg_wr(a[7:0], 8'hA5);
      reg_rd(a[7:0], 8'h00);
    end
    reg_rd(8'h10, 8'h00);
  endtask

  // aux output follows the controller bit, inverted when bit 7 is 0
  task automatic t_aux;
    for (int m = 0; m < 4; m++) begin
      reg_wr(kbc_pkg::CFG_IDX, (m >= 2) ? 8'h80 : 8'h00);
      @(posedge i_sys_clk);
      i_aux <= m[0];
      tick(3);
      check({7'h00, o_aux}, {7'h00, m[0] ^ (m < 2)});
    end
  endtask

  // every isolation setting; wake lines must keep showing the pins
  task automatic t_iso;
    logic [7:0] c;
    @(posedge i_sys_clk);
    {i_kclk, i_keyboard_data_line, i_mclk, i_mouse_data_line} <= 4'h0;
    for (int m = 0; m < 4; m++) begin
      c = {1'b0, m[1], m[0], 5'h00};
      reg_wr(kbc_pkg::CFG_IDX, c);
      tick(4);
      check({6'h00, o_mclk_c, o_mouse_data_line_c}, {6'h00, c[6], c[6]});
      check({6'h00, o_kclk_c, o_keyboard_data_line_c}, {6'h00, c[5], c[5]});
      check({6'h00, o_kwake, o_mwake}, 8'h00);
    end
    @(posedge i_sys_clk);
    {i_kclk, i_keyboard_data_line, i_mclk, i_mouse_data_line} <= 4'hF;
    tick(4);
    check({6'h00, o_kwake, o_mwake}, 8'h03);
  endtask

  // one interrupt latched-only, the other raw AND latched
  task automatic t_irq(input logic [7:0] c);
    reg_wr(kbc_pkg::CFG_IDX, c);
    @(posedge i_sys_clk);
    {i_kraw, i_mraw} <= 2'b11;
    tick(3);
    check({6'h00, o_kirq, o_mirq}, 8'h03);
    @(posedge i_sys_clk);
    {i_kraw, i_mraw} <= 2'b00;
    tick(3);
    check({6'h00, o_kirq, o_mirq}, {6'h00, c[3], c[4]});
    reg_rd(kbc_pkg::STAT_IDX, 8'h03);
    check({7'h00, o_irq}, 8'h00);
    reg_wr(kbc_pkg::MASK_IDX, 8'h02);
    tick(1);
    check({7'h00, o_irq}, 8'h01);
    reg_wr(kbc_pkg::STAT_IDX, 8'h02);
    tick(1);
    check({7'h00, o_irq}, 8'h00);
    reg_wr(kbc_pkg::STAT_IDX, 8'h01);
    reg_wr(kbc_pkg::MASK_IDX, 8'h00);
    reg_rd(kbc_pkg::STAT_IDX, 8'h00);
    @(posedge i_sys_clk);
    {i_kack, i_mack} <= 2'b11;
    @(posedge i_sys_clk);
    {i_kack, i_mack} <= 2'b00;
    tick(2);
    check({6'h00, o_kirq, o_mirq}, 8'h00);
  endtask

  task automatic gp_access(input logic wr, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_gp_wr    <= wr;
    i_gp_rd    <= ~wr;
    i_gp_wdata <= d;
    @(posedge i_sys_clk);
    i_gp_wr    <= 1'b0;
    i_gp_rd    <= 1'b0;
    #1;
  endtask

  // fast gate port refused while disabled, then a full reset pulse
  task automatic t_gate;
    int n;
    reg_wr(kbc_pkg::CFG_IDX, 8'h00);
    gp_access(1'b1, 8'h03);
    check({6'h00, o_a20, o_krst}, 8'h00);
    gp_access(1'b0, 8'h00);
    check({7'h00, o_gp_resp}, 8'h00);
    check(o_gp_rdata, 8'h00);
    reg_rd(kbc_pkg::STAT_IDX, 8'h00);
    reg_wr(kbc_pkg::CFG_IDX, 8'h04);
    gp_access(1'b1, 8'h03);
    n = 0;
    while (o_krst === 1'b1 && n < 50) begin
      n++;
      tick(1);
    end
    check(n[7:0], 8'(kbc_pkg::KRST_PULSE_CYC));
    gp_access(1'b0, 8'h00);
    check({7'h00, o_gp_resp}, 8'h01);
    check(o_gp_rdata, 8'h02);
    reg_rd(kbc_pkg::STAT_IDX, 8'h04);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    failures   = 0;
    n_compared = 0;
    i_rst_n = 1'b0;
    {i_wr, i_rd, i_addr, i_wdata} = '0;
    {i_kclk, i_keyboard_data_line, i_mclk, i_mouse_data_line} = 4'hF;
    {i_aux, i_kraw, i_mraw, i_kack, i_mack} = '0;
    {i_gp_wr, i_gp_rd, i_gp_wdata} = '0;
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_regs;
    t_aux;
    t_iso;
    t_irq(8'h10);
    t_irq(8'h08);
    t_gate;
    tick(2);
    print_verdict;
  end

  // whole run is well under two thousand cycles
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    failures++;
    print_verdict;
  end
endmodule
